// *** include/sensor_regs.svh ***
// Register offsets, field positions, link framing and timing constants
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH

// ------------------------------------------------------------
// Host APB registers
// ------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_DATA 12'h008
`define CTRL_CMD_LSB 0
`define CTRL_GO_BIT 8
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_MCLK_BIT 2
`define DATA_RST 16'h0000

// ------------------------------------------------------------
// Link framing
// ------------------------------------------------------------
`define FRAME_START 3'h7
`define FRAME_STOP 3'h0
`define RST_PATTERN_DEF 21'h155555
`define SETUP_CODES_DEF 24'hC3659A
`define RESULT_BITS 16
`define READ_PULSES_A 17
`define READ_PULSES_B 18
`define ACK_PULSES 2
`define RST_PULSES 21
`define CMD_PULSES 31

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PCLK_PERIOD_NS 10
`define CONV_TIME_NS 35000000
`define SCLK_MIN_PERIOD_NS 2000
`define CONV_CYCLES_DEF (`CONV_TIME_NS / `PCLK_PERIOD_NS)
`define SCLK_HALF_CYCLES ((`SCLK_MIN_PERIOD_NS / 2 + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)

`endif

// *** include/sensor_pkg.sv ***
// Shared types of the sensor link ends
package sensor_pkg;

   typedef enum logic [2:0] {
      CMD_PRESSURE,
      CMD_TEMPERATURE,
      CMD_CAL_ONE,
      CMD_CAL_TWO,
      CMD_CAL_THREE,
      CMD_CAL_FOUR,
      CMD_RESET
   } cmd_e;

   typedef enum logic [1:0] {D_IDLE, D_ACK, D_CONV, D_SHIFT} dev_state_e;

   typedef enum logic [2:0] {H_IDLE, H_SEND, H_ACK, H_EXTRA, H_CONV, H_READ} host_state_e;

endpackage

// *** include/sensor_link_if.sv ***
// Three-wire serial link between host and sensor
`timescale 1ns/1ns
interface sensor_link_if;
   logic sclk;
   logic din;
   logic dout;
   modport dev (input sclk, input din, output dout);
   modport host (output sclk, output din, input dout);
endinterface

// *** hdl/sync_edge.sv ***
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ns
module sync_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

// *** hdl/sensor_device.sv ***
// Sensor end of the three-wire link: command decode, conversion, readout
//
// Contract
// RL1: Pressure and temperature results are 16-bit words
// RL2: 64 calibration bits readable as four words
// RL3: Six coefficients packed MSB first into words
// RL4: Host reads calibration words once after reset (host here reads a word only on a CTRL command)
// RL5: Device samples and launches on rising clock
// RL6: Host captures and changes data on falling clock
// RL7: Host alone generates clock and starts transfers
// RL8: Last command selects what data-out shows
// RL9: Seven commands: two conversions, four words, reset
// RL10: Three high, setup, three low frame commands
// RL11: Setup field is four bits wide
// RL12: Conversion start acknowledged by data-out rising
// RL13: Host gives two pulses then holds clock low
// RL14: Conversion end shown by data-out falling
// RL15: Host gives 17 pulses to read result
// RL16: Paused readout resumes at same bit
// RL17: Host reads result before next conversion
// RL18: 21-bit reset pattern restarts protocol anywhere
// RL19: Host ignores data-out during reset pattern
// RL20: Host sends reset pattern before each command
// RL21: Words one/three and two/four share shapes
// RL22: Host polls pressure and temperature periodically (host here converts only on a CTRL command)
// RL23: Master clock may stop while idle
// RL24: Setup codes and reset pattern are parameters
`timescale 1ns/1ns
`include "sensor_regs.svh"
module sensor_device
   import sensor_pkg::*;
#(
   parameter logic [12:0] COEF_ONE = 13'h0AAA,
   parameter logic [12:0] COEF_TWO = 13'h1555,
   parameter logic [9:0] COEF_THREE = 10'h2C3,
   parameter logic [8:0] COEF_FOUR = 9'h0F1,
   parameter logic [11:0] COEF_FIVE = 12'h9A6,
   parameter logic [6:0] COEF_SIX = 7'h35,
   parameter logic [20:0] RST_PATTERN = `RST_PATTERN_DEF,
   parameter logic [23:0] SETUP_CODES = `SETUP_CODES_DEF,
   parameter int unsigned CONV_CYCLES = `CONV_CYCLES_DEF
)(
   input wire logic pclk,
   input wire logic presetn,
   sensor_link_if.dev link,
   input wire logic [15:0] pressure_result,
   input wire logic [15:0] temperature_result,
   output logic conv_active,
   output logic conv_is_temp
);

   // ------------------------------------------------------------
   // Link input sampling
   // ------------------------------------------------------------
   logic sclk_rise;
   logic din_lvl;

   sync_edge u_sclk (
      .pclk(pclk),
      .presetn(presetn),
      .d(link.sclk),
      .level(),
      .rise(sclk_rise),
      .fall()
   );

   sync_edge u_din (
      .pclk(pclk),
      .presetn(presetn),
      .d(link.din),
      .level(din_lvl),
      .rise(),
      .fall()
   );

   // ------------------------------------------------------------
   // Calibration store
   // ------------------------------------------------------------
   logic [15:0] calibration_store [4];

   assign calibration_store[0] = {COEF_ONE, COEF_TWO[12:10]}; // RL3
   assign calibration_store[1] = {COEF_TWO[9:0], COEF_FIVE[11:6]}; // RL3
   assign calibration_store[2] = {COEF_THREE, COEF_FIVE[5:0]}; // RL3
   assign calibration_store[3] = {COEF_FOUR, COEF_SIX}; // RL3

   // ------------------------------------------------------------
   // Command and reset detection
   // ------------------------------------------------------------
   dev_state_e st_r;
   logic [20:0] hist_r;
   logic dout_r;
   logic [4:0] cnt_r;
   logic [15:0] out_r;
   logic lead_r;
   logic temp_r;
   logic [31:0] timer_r;
   logic [5:0] code_hit;
   cmd_e cmd_dec;

   wire logic [20:0] hist_nxt = {hist_r[19:0], din_lvl};
   wire logic rst_hit = sclk_rise && (hist_nxt == RST_PATTERN); // RL18
   wire logic cmd_hit = sclk_rise && (st_r == D_IDLE) && (|code_hit); // RL10

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_code
         assign code_hit[g] = hist_nxt[9:0] == {`FRAME_START, SETUP_CODES[4*g +: 4], `FRAME_STOP}; // RL11 RL24
      end
   endgenerate

   always_comb begin
      cmd_dec = CMD_PRESSURE;
      for (int i = 5; i >= 0; i--) begin
         if (code_hit[i]) begin
            cmd_dec = cmd_e'(3'(i)); // RL9
         end
      end
   end

   wire logic is_conv = (cmd_dec == CMD_PRESSURE) || (cmd_dec == CMD_TEMPERATURE);
   wire logic [1:0] word_idx = 2'(3'(cmd_dec) - 3'(CMD_CAL_ONE));
   wire logic word_lead = (cmd_dec == CMD_CAL_TWO) || (cmd_dec == CMD_CAL_FOUR); // RL21
   wire logic conv_end = timer_r == (CONV_CYCLES - 32'd1);
   wire logic [15:0] conv_code = temp_r ? temperature_result : pressure_result; // RL1

   // ------------------------------------------------------------
   // Protocol state
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_r <= 21'h00000;
      end else if (sclk_rise) begin
         hist_r <= (rst_hit || cmd_hit) ? 21'h00000 : hist_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= D_IDLE;
         dout_r <= 1'b0;
         cnt_r <= 5'h00;
         out_r <= 16'h0000;
         lead_r <= 1'b0;
         temp_r <= 1'b0;
         timer_r <= 32'h00000000;
      end else if (rst_hit) begin
         st_r <= D_IDLE; // RL18
         dout_r <= 1'b0;
         cnt_r <= 5'h00;
      end else begin
         unique case (st_r)
            D_IDLE: begin
               if (cmd_hit && is_conv) begin
                  st_r <= D_ACK;
                  dout_r <= 1'b1; // RL12
                  cnt_r <= 5'h00;
                  temp_r <= cmd_dec == CMD_TEMPERATURE;
               end else if (cmd_hit) begin
                  st_r <= D_SHIFT; // RL8
                  out_r <= calibration_store[word_idx]; // RL2
                  lead_r <= word_lead; // RL21
                  cnt_r <= 5'h00;
               end
            end
            D_ACK: begin
               if (sclk_rise) begin
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r == 5'(`ACK_PULSES - 1)) begin
                     st_r <= D_CONV;
                     timer_r <= 32'h00000000;
                  end
               end
            end
            D_CONV: begin
               timer_r <= timer_r + 32'h00000001;
               if (conv_end) begin
                  st_r <= D_SHIFT;
                  dout_r <= 1'b0; // RL14
                  out_r <= conv_code; // RL1
                  lead_r <= 1'b0;
                  cnt_r <= 5'h00;
               end
            end
            D_SHIFT: begin
               // Shifting advances only on clock edges, so a paused clock holds the bit
               if (sclk_rise) begin // RL16
                  if (lead_r) begin
                     lead_r <= 1'b0;
                     dout_r <= 1'b0;
                  end else if (cnt_r < 5'(`RESULT_BITS)) begin
                     dout_r <= out_r[15]; // RL5
                     out_r <= {out_r[14:0], 1'b0};
                     cnt_r <= cnt_r + 5'h01;
                  end else begin
                     dout_r <= 1'b0;
                     st_r <= D_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.dout = dout_r; // RL8
   assign conv_active = st_r == D_CONV;
   assign conv_is_temp = temp_r;

endmodule

// *** hdl/sensor_host.sv ***
// Host end of the three-wire link, commanded over APB registers
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
`include "sensor_regs.svh"
module sensor_host
   import sensor_pkg::*;
#(
   parameter logic [20:0] RST_PATTERN = `RST_PATTERN_DEF,
   parameter logic [23:0] SETUP_CODES = `SETUP_CODES_DEF
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mclk_run,
   sensor_link_if.host link
);

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   host_state_e st_r;
   cmd_e cmd_r;
   logic done_r;
   logic [15:0] data_r;
   logic [31:0] prdata_r;
   logic dout_lvl;

   wire logic sel_ctrl = paddr == `OFS_CTRL;
   wire logic sel_status = paddr == `OFS_STATUS;
   wire logic sel_data = paddr == `OFS_DATA;
   wire logic mapped = sel_ctrl || sel_status || sel_data;
   wire logic wr_en = psel && penable && pwrite;
   wire logic [2:0] cmd_field = pwdata[`CTRL_CMD_LSB +: 3];
   wire logic busy = st_r != H_IDLE;
   // A new command is taken only once the previous transfer is fully read
   wire logic go = wr_en && sel_ctrl && pwdata[`CTRL_GO_BIT] && !busy && (cmd_field <= 3'(CMD_RESET)); // RL17 RL7
   wire logic [31:0] status_word = {29'h0, busy, done_r, busy} & 32'h00000007;
   wire logic [31:0] rd_mux = sel_status ? status_word :
                              sel_data ? {16'h0000, data_r} :
                              sel_ctrl ? {29'h0, cmd_r} : 32'h00000000;

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;
   assign mclk_run = busy; // RL23

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata_r <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Serial clock divider
   // ------------------------------------------------------------
   logic sclk_r;
   logic [6:0] div_r;

   wire logic run = (st_r == H_SEND) || (st_r == H_EXTRA) || (st_r == H_READ);
   wire logic tick = div_r == 7'(`SCLK_HALF_CYCLES - 1);
   wire logic fall_ev = tick && sclk_r; // RL6

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_r <= 1'b0;
         div_r <= 7'h00;
      end else if (run || sclk_r) begin
         div_r <= tick ? 7'h00 : div_r + 7'h01;
         sclk_r <= tick ? !sclk_r : sclk_r; // RL7
      end else begin
         div_r <= 7'h00;
      end
   end

   sync_edge u_dout (
      .pclk(pclk),
      .presetn(presetn),
      .d(link.dout),
      .level(dout_lvl),
      .rise(),
      .fall()
   );

   // ------------------------------------------------------------
   // Transfer sequencing
   // ------------------------------------------------------------
   logic [30:0] tx_r;
   logic [15:0] rx_r;
   logic [4:0] pcnt_r;
   logic din_r;

   // Reset pattern precedes every command frame
   wire logic [30:0] tx_vec = {RST_PATTERN, `FRAME_START, SETUP_CODES[4*cmd_field +: 4], `FRAME_STOP}; // RL20 RL10 RL11
   wire logic last = pcnt_r == 5'h01;
   wire logic conv_cmd = (cmd_r == CMD_PRESSURE) || (cmd_r == CMD_TEMPERATURE);
   wire logic long_read = (cmd_r == CMD_CAL_TWO) || (cmd_r == CMD_CAL_FOUR); // RL21

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= H_IDLE;
         cmd_r <= CMD_RESET;
         tx_r <= 31'h0000000;
         rx_r <= 16'h0000;
         pcnt_r <= 5'h00;
         din_r <= 1'b0;
         done_r <= 1'b0;
         data_r <= `DATA_RST;
      end else begin
         unique case (st_r)
            H_IDLE: begin
               if (go) begin
                  st_r <= H_SEND;
                  cmd_r <= cmd_e'(cmd_field); // RL4 RL9
                  din_r <= tx_vec[30];
                  tx_r <= {tx_vec[29:0], 1'b0};
                  pcnt_r <= (cmd_field == 3'(CMD_RESET)) ? 5'(`RST_PULSES) : 5'(`CMD_PULSES);
                  done_r <= 1'b0;
               end
            end
            H_SEND: begin
               // Data-out is not looked at while the frame is sent
               if (fall_ev) begin // RL19
                  din_r <= last ? 1'b0 : tx_r[30];
                  tx_r <= {tx_r[29:0], 1'b0};
                  pcnt_r <= pcnt_r - 5'h01;
                  if (last && cmd_r == CMD_RESET) begin
                     st_r <= H_IDLE;
                     done_r <= 1'b1;
                  end else if (last && conv_cmd) begin
                     st_r <= H_ACK;
                  end else if (last) begin
                     st_r <= H_READ;
                     pcnt_r <= long_read ? 5'(`READ_PULSES_B) : 5'(`READ_PULSES_A);
                  end
               end
            end
            H_ACK: begin
               if (dout_lvl) begin
                  st_r <= H_EXTRA;
                  pcnt_r <= 5'(`ACK_PULSES); // RL13
               end
            end
            H_EXTRA: begin
               if (fall_ev) begin
                  pcnt_r <= pcnt_r - 5'h01;
                  st_r <= last ? H_CONV : H_EXTRA; // RL13
               end
            end
            H_CONV: begin
               if (!dout_lvl) begin
                  st_r <= H_READ;
                  pcnt_r <= 5'(`READ_PULSES_A); // RL15
               end
            end
            H_READ: begin
               if (fall_ev) begin
                  rx_r <= last ? rx_r : {rx_r[14:0], dout_lvl}; // RL6
                  pcnt_r <= pcnt_r - 5'h01;
                  if (last) begin
                     st_r <= H_IDLE;
                     data_r <= rx_r; // RL22
                     done_r <= 1'b1;
                  end
               end
            end
            default: begin
               st_r <= H_IDLE;
            end
         endcase
      end
   end

   assign link.sclk = sclk_r;
   assign link.din = din_r;

endmodule

// *** testbench/sensor_link_sva.sv ***
// Concurrent checks on the three-wire link between host and sensor ends
`timescale 1ns/1ns
`include "sensor_regs.svh"
module sensor_link_sva #(
   parameter logic [20:0] RST_PATTERN = `RST_PATTERN_DEF,
   parameter logic [23:0] SETUP_CODES = `SETUP_CODES_DEF,
   parameter int unsigned CONV_CYCLES = 400
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout
);
   // ------------------------------------------------------------
   // Link phase tracking
   // ------------------------------------------------------------
   logic sclk_r;
   logic [30:0] bits_r;
   logic [1:0] stage_r;
   logic [4:0] rcnt_r;
   logic [15:0] cyc_r;
   logic [7:0] hi_r;
   wire sclk_rise = sclk & ~sclk_r;
   wire sclk_fall = ~sclk & sclk_r;
   wire [30:0] bits_nxt = {bits_r[29:0], din};
   wire press_hit = bits_nxt == {RST_PATTERN, 3'h7, SETUP_CODES[3:0], 3'h0};
   wire temp_hit = bits_nxt == {RST_PATTERN, 3'h7, SETUP_CODES[7:4], 3'h0};
   wire conv_frame = sclk_rise && stage_r == 2'h0 && (press_hit || temp_hit);
   wire second_rise = stage_r == 2'h1 && sclk_rise && rcnt_r == 5'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_r <= 1'h0;
         bits_r <= 31'h0;
         stage_r <= 2'h0;
         rcnt_r <= 5'h0;
         cyc_r <= 16'h0;
         hi_r <= 8'h0;
      end else begin
         sclk_r <= sclk;
         hi_r <= sclk ? hi_r + {7'h0, hi_r != 8'hFF} : 8'h0;
         cyc_r <= second_rise ? 16'h0 : cyc_r + 16'h1;
         if (sclk_rise) begin
            bits_r <= bits_nxt;
         end
         if (conv_frame || (stage_r == 2'h2 && !dout)) begin
            stage_r <= stage_r + 2'h1;
            rcnt_r <= 5'h0;
         end else if (sclk_rise && stage_r != 2'h0) begin
            rcnt_r <= rcnt_r + 5'h1;
         end else if (sclk_fall && stage_r == 2'h1 && rcnt_r == 5'h2) begin
            stage_r <= 2'h2;
         end else if (sclk_fall && stage_r == 2'h3 && rcnt_r == 5'h11) begin
            stage_r <= 2'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_din_on_fall;
      $changed(din) |-> !sclk;
   endproperty
   a_din_on_fall: assert property (p_din_on_fall)
      else $error("din changed while sclk high");
   property p_dout_launch;
      $changed(dout) && stage_r != 2'h2 |-> sclk;
   endproperty
   a_dout_launch: assert property (p_dout_launch)
      else $error("dout changed outside an sclk high phase");
   property p_ack;
      conv_frame |-> ##[1:8] dout;
   endproperty
   a_ack: assert property (p_ack)
      else $error("no acknowledge after conversion command");
   property p_hold_low;
      stage_r == 2'h2 |-> !sclk;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("sclk pulsed during conversion");
   property p_conv_time;
      stage_r == 2'h2 && $fell(dout) |-> cyc_r >= CONV_CYCLES - 2 && cyc_r <= CONV_CYCLES + 12;
   endproperty
   a_conv_time: assert property (p_conv_time)
      else $error("conversion end at wrong time");
   property p_conv_bound;
      stage_r == 2'h2 |-> cyc_r <= CONV_CYCLES + 12;
   endproperty
   a_conv_bound: assert property (p_conv_bound)
      else $error("conversion never ended");
   property p_read_end;
      stage_r == 2'h3 && sclk_fall && rcnt_r == 5'h11 |-> !dout;
   endproperty
   a_read_end: assert property (p_read_end)
      else $error("dout not low after seventeenth readout pulse");
   property p_sclk_high;
      sclk_fall |-> hi_r >= 8'h63;
   endproperty
   a_sclk_high: assert property (p_sclk_high)
      else $error("sclk high phase too short");

   c_conv: cover property (conv_frame);
   c_read: cover property (stage_r == 2'h3 && sclk_fall && rcnt_r == 5'h11);
   c_word: cover property ($rose(dout) && stage_r == 2'h0);
endmodule

// *** testbench/pressure_sensor_serial_readout_test.sv ***
// Self-checking bench joining the host and sensor ends of the link
`timescale 1ns/1ns
`include "sensor_regs.svh"
module pressure_sensor_serial_readout_test
   import sensor_pkg::*;
;
   localparam int unsigned CONV = 400;
   localparam logic [12:0] coef_one = 13'h1A5C;
   localparam logic [12:0] coef_two = 13'h0B37;
   localparam logic [9:0] coef_three = 10'h1E9;
   localparam logic [8:0] coef_four = 9'h14B;
   localparam logic [11:0] coef_five = 12'hC71;
   localparam logic [6:0] coef_six = 7'h2E;
   logic pclk;
   logic presetn;
   logic [11:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic mclk_run;
   logic conv_active;
   logic conv_is_temp;
   logic [15:0] press_val;
   logic [15:0] temp_val;
   int error_cnt;
   int n_compared;
   int conv_cyc;

   // Counts the cycles in which the device reports a running conversion
   always @(posedge pclk) begin
      if (conv_active === 1'b1) begin
         conv_cyc <= conv_cyc + 1;
      end
   end

   sensor_link_if link_i();
   sensor_host u_sensor_host (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk_run(mclk_run),
      .link(link_i)
   );
   sensor_device #(
      .COEF_ONE(coef_one), .COEF_TWO(coef_two), .COEF_THREE(coef_three), .COEF_FOUR(coef_four),
      .COEF_FIVE(coef_five), .COEF_SIX(coef_six),
      .CONV_CYCLES(CONV)
   ) u_sensor_device (
      .pclk(pclk), .presetn(presetn), .link(link_i), .pressure_result(press_val),
      .temperature_result(temp_val), .conv_active(conv_active), .conv_is_temp(conv_is_temp)
   );
   sensor_link_sva #(.CONV_CYCLES(CONV)) u_sensor_link_sva (
      .pclk(pclk), .presetn(presetn), .sclk(link_i.sclk), .din(link_i.din), .dout(link_i.dout)
   );

   // ------------------------------------------------------------
   // Expectations and reporting
   // ------------------------------------------------------------
   function automatic logic [15:0] cal_word(input int k);
      case (k)
         0: return {coef_one, coef_two[12:10]};
         1: return {coef_two[9:0], coef_five[11:6]};
         2: return {coef_three, coef_five[5:0]};
         default: return {coef_four, coef_six};
      endcase
   endfunction

   task automatic finish_test();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ------------------------------------------------------------
   // APB master and command sequence
   // ------------------------------------------------------------
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         error_cnt++;
         finish_test();
      end
   endtask

   task automatic run(input logic [2:0] c, input logic [15:0] x);
      logic [31:0] r;
      logic e;
      int n;
      int c0;
      c0 = conv_cyc;
      apb(`OFS_CTRL, 1'h1, {23'h0, 1'h1, 5'h0, c}, r, e);
      apb(`OFS_STATUS, 1'h0, 32'h0, r, e);
      chk(r, 32'h5);
      chk({31'h0, mclk_run}, 32'h1);
      apb(`OFS_CTRL, 1'h1, {31'h80, c == 3'h0}, r, e);
      n = 0;
      r = 32'h0;
      while (r[1] !== 1'h1 && n < 5000) begin
         apb(`OFS_STATUS, 1'h0, 32'h0, r, e);
         n++;
      end
      if (n >= 5000) begin
         error_cnt++;
         finish_test();
      end
      chk(r, 32'h2);
      if (c != CMD_RESET) begin
         apb(`OFS_DATA, 1'h0, 32'h0, r, e);
         chk(r, {16'h0, x});
      end
      if (c < 3'h2) begin
         chk({31'h0, conv_is_temp}, {31'h0, c[0]});
         chk(32'(conv_cyc - c0), 32'(CONV));
      end
   endtask

   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      logic [31:0] r;
      logic e;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      press_val = 16'h0;
      temp_val = 16'h0;
      error_cnt = 0;
      n_compared = 0;
      void'($urandom(83299));
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      apb(`OFS_CTRL, 1'h0, 32'h0, r, e);
      chk(r, 32'h00000006);
      apb(`OFS_STATUS, 1'h0, 32'h0, r, e);
      chk(r, 32'h0);
      apb(`OFS_DATA, 1'h0, 32'h0, r, e);
      chk(r, {16'h0, `DATA_RST});
      apb(12'h00C, 1'h0, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      apb(`OFS_CTRL, 1'h1, 32'h107, r, e);
      apb(`OFS_STATUS, 1'h0, 32'h0, r, e);
      chk(r, 32'h0);
      for (int k = 0; k < 6; k++) begin
         @(posedge pclk);
         press_val <= 16'($urandom);
         temp_val <= 16'($urandom);
         @(posedge pclk);
         run(k[2:0], k == 0 ? press_val : k == 1 ? temp_val : cal_word(k - 2));
      end
      run(CMD_RESET, 16'h0);
      @(posedge pclk);
      press_val <= 16'h8001;
      run(CMD_PRESSURE, 16'h8001);
      finish_test();
   end
endmodule
